// >>> hw/temp_channel_alarm_status.sv
// Alarm status, masking and measurement sequencing of a seven-channel monitor.
// Assumes a command-byte register port and a front end that presents the
// result of conv_chan_o on meas_temp_i when the conversion window ends.
//
// Function
// - Overtemp mask bits 5,4,3,0 gate output.
// - Local alert flag bit 6 above limit.
// - Remote alert flags bits 0-5 above limits.
// - Config1 bit 3 enables resistance cancellation.
// - Cancellation adds 125 ms to channel 1.
// - Config1 bit 2 beta compensation, on at reset.
// - Open diode or anode at supply: fault.
// - Sequencer skips faulted remote channels.
// - Masked channels never assert alarm outputs.
// - Alert mask bits 0-5 remote, 6 local.
// - Status2 clears on read, output unchanged.
// - Fault releases only past 4 degree hysteresis.
`timescale 1ns/1ps
`default_nettype none
module temp_channel_alarm_status
   import temp_alarm_pkg::*;
#(
   parameter int         TIMER_W         = 24,
   parameter int         BASE_CONV_CYC   = 50_000,
   parameter int         RC_EXTRA_CYC    = RC_EXTRA_MS * CLK_KHZ,
   parameter logic [7:0] MFR_ID          = 8'h5C  // Arbitrary value
)
(
   input  wire logic        mclk_i,
   input  wire logic        reset_i,
   input  wire logic        ce_i,
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   input  wire logic [7:0]  reg_wdata_i,
   output logic      [7:0]  reg_rdata_o,
   input  wire logic [7:0]  meas_temp_i,
   input  wire logic [5:0]  diode_anode_open_i,
   input  wire logic [5:0]  diode_cathode_open_i,
   input  wire logic [5:0]  diode_anode_at_supply_i,
   output logic      [2:0]  conv_chan_o,
   output logic             conv_sample_o,
   output logic             rc_enable_o,
   output logic             bc_enable_o,
   output logic             alert_oe_n_o,
   output logic             overtemp_out_oe_n_o
);

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef struct packed {
      seq_e             state;
      logic [CH_W-1:0]  chan;
      logic [TIMER_W-1:0] timer;
      logic [7:0]       cfg1;
      logic [7:0]       mask_alert;
      logic [7:0]       mask_ot;
      logic [7:0]       status1;
      logic [7:0]       status2;
      logic [7:0]       fault;
      logic [7:0]       alert_act;
      logic [7:0]       ot_act;
      logic [6:0][7:0]  alert_lim;
      logic [6:0][7:0]  ot_lim;
      logic [6:0][7:0]  temp;
      logic [7:0]       rdata;
      logic             sample;
      logic             alert_oe_n;
      logic             ot_oe_n;
   } state_s;

   localparam state_s ST_RST = '{state: SEQ_STANDBY, cfg1: CFG1_RST, alert_lim: ALERT_LIM_RST,
                                 ot_lim: OT_LIM_RST, alert_oe_n: 1'b1, ot_oe_n: 1'b1,
                                 default: '0};
   localparam logic [TIMER_W-1:0] BASE_LOAD = TIMER_W'(BASE_CONV_CYC - 1);
   localparam logic [TIMER_W-1:0] RC_LOAD   = TIMER_W'(BASE_CONV_CYC - 1 + RC_EXTRA_CYC);

   state_s            s_reg;
   state_s            s_next;
   logic [7:0]        a_hit;
   logic [7:0]        o_hit;
   logic [2:0]        nxt_chan;
   logic              load_ev;
   logic              sample_ev;
   logic [5:0]        fault_raw;
   logic              soft_rst;

   // -----------------------------------------------------------------
   // Comparators, one alert per channel plus one overtemp per remote channel, results at status bit positions
   // -----------------------------------------------------------------
   for (genvar c = 0; c < NUM_CH; c++)
   begin : g_cmp
      localparam int AP = (c == 0) ? 6 : c - 1;
      temp_limit_cmp u_alert (
         .temp_i   (meas_temp_i),
         .limit_i  (s_reg.alert_lim[c]),
         .active_i (s_reg.alert_act[AP]),
         .active_o (a_hit[AP])
      );
      if (c != 0)
      begin : g_ot
         temp_limit_cmp u_ot (
            .temp_i   (meas_temp_i),
            .limit_i  (s_reg.ot_lim[c]),
            .active_i (s_reg.ot_act[c-1]),
            .active_o (o_hit[c-1])
         );
      end
   end
   assign a_hit[7] = 1'b0;
   assign o_hit[7:6] = 2'b00;

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   function automatic logic [2:0] next_chan(input logic [2:0] cur, input logic [7:0] flt);
      logic [2:0] c;
      logic [2:0] r;
      logic       found;
      c = cur;
      r = LOCAL_CH;
      found = 1'b0;
      for (int i = 0; i < NUM_CH; i++)
      begin
         c = (c == LAST_CH) ? LOCAL_CH : c + 3'h1;
         if (!found && (c == LOCAL_CH || !flt[c]))
         begin
            r = c;
            found = 1'b1;
         end
      end
      return r;
   endfunction

   function automatic logic [7:0] rd_mux(input state_s st, input logic [7:0] a);
      logic [7:0] d;
      d = 8'h00;
      unique case (a)
         ADDR_CFG1:   d = st.cfg1;
         ADDR_CFG2:   d = st.mask_alert;
         ADDR_CFG3:   d = st.mask_ot;
         ADDR_ST1:    d = st.status1;
         ADDR_ST2:    d = st.status2;
         ADDR_ST3:    d = st.fault;
         ADDR_MFR_ID: d = MFR_ID;
         default:
         begin
            if (a[7:3] == ADDR_TEMP_HI && a[2:0] != ALIM_LOCAL_IDX)
               d = st.temp[a[2:0]];
            else if (a[7:4] == ADDR_ALIM_HI && a[3] == 1'b0 && a[2:0] != LOCAL_CH)
               d = st.alert_lim[(a[2:0] == ALIM_LOCAL_IDX) ? LOCAL_CH : a[2:0]];
            else if (a[7:4] == ADDR_OLIM_HI && a[3] == 1'b0 && OT_CH_MASK[a[2:0]])
               d = st.ot_lim[a[2:0]];
         end
      endcase
      return d;
   endfunction

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   assign fault_raw = (diode_anode_open_i & diode_cathode_open_i) | diode_anode_at_supply_i;
   assign nxt_chan  = next_chan(s_reg.chan, s_reg.fault);
   assign sample_ev = (s_reg.state == SEQ_CONVERT) && (s_reg.timer == '0);
   assign soft_rst  = reg_wr_i && reg_addr_i == ADDR_CFG1 && reg_wdata_i[CFG1_POR];

   always_comb
   begin
      logic [7:0] a_sel;
      logic [7:0] o_sel;
      a_sel   = (s_reg.chan == LOCAL_CH) ? ST1_LOCAL : ONE_HOT0 << (s_reg.chan - 3'h1);
      o_sel   = (s_reg.chan == LOCAL_CH) ? 8'h00 : (ONE_HOT0 << (s_reg.chan - 3'h1)) & OT_BITS;
      s_next  = s_reg;
      load_ev = 1'b0;
      s_next.sample = 1'b0;
      s_next.fault  = {1'b0, fault_raw, 1'b0};
      // Register port; clear-on-read happens before sets so a set wins
      if (reg_rd_i)
      begin
         s_next.rdata = rd_mux(s_reg, reg_addr_i);
         if (reg_addr_i == ADDR_ST1)
            s_next.status1 = 8'h00;
         if (reg_addr_i == ADDR_ST2)
            s_next.status2 = 8'h00;
      end
      if (reg_wr_i)
      begin
         unique case (reg_addr_i)
            ADDR_CFG1: s_next.cfg1       = reg_wdata_i & CFG1_WMASK;
            ADDR_CFG2: s_next.mask_alert = reg_wdata_i & ST1_BITS;
            ADDR_CFG3: s_next.mask_ot    = reg_wdata_i & OT_BITS;
            default:
            begin
               if (reg_addr_i[7:4] == ADDR_ALIM_HI && reg_addr_i[3] == 1'b0 && reg_addr_i[2:0] != LOCAL_CH)
                  s_next.alert_lim[(reg_addr_i[2:0] == ALIM_LOCAL_IDX) ? LOCAL_CH : reg_addr_i[2:0]] = reg_wdata_i;
               else if (reg_addr_i[7:4] == ADDR_OLIM_HI && reg_addr_i[3] == 1'b0 && OT_CH_MASK[reg_addr_i[2:0]])
                  s_next.ot_lim[reg_addr_i[2:0]] = reg_wdata_i;
            end
         endcase
      end
      // Measurement sequence
      unique case (s_reg.state)
         SEQ_STANDBY:
         begin
            if (!s_reg.cfg1[CFG1_STOP])
            begin
               s_next.state = SEQ_CONVERT;
               s_next.chan  = LOCAL_CH;
               s_next.timer = BASE_LOAD;
            end
         end
         SEQ_CONVERT:
         begin
            if (sample_ev)
            begin
               s_next.sample          = 1'b1;
               s_next.temp[s_reg.chan] = meas_temp_i;
               s_next.alert_act = (s_reg.alert_act & ~a_sel) | (a_hit & a_sel);
               s_next.status1   = s_next.status1 | (a_hit & a_sel);
               s_next.ot_act    = (s_reg.ot_act & ~o_sel) | (o_hit & o_sel);
               s_next.status2   = s_next.status2 | (o_hit & o_sel);
               if (s_reg.cfg1[CFG1_STOP])
                  s_next.state = SEQ_STANDBY;
               else
               begin
                  load_ev      = 1'b1;
                  s_next.chan  = nxt_chan;
                  s_next.timer = (nxt_chan == 3'h1 && s_reg.cfg1[CFG1_RC]) ? RC_LOAD : BASE_LOAD;
               end
            end
            else
               s_next.timer = s_reg.timer - TIMER_W'(1);
         end
      endcase
      s_next.alert_oe_n = ~|(s_next.status1 & ~s_next.mask_alert);
      s_next.ot_oe_n    = ~|(s_next.ot_act & ~s_next.mask_ot);
      if (soft_rst)
         s_next = ST_RST;
   end

   always_ff @(posedge mclk_i or posedge reset_i)
   begin
      if (reset_i)
         s_reg <= ST_RST;
      else if (ce_i)
         s_reg <= s_next;
   end

   assign reg_rdata_o         = s_reg.rdata;
   assign conv_chan_o         = s_reg.chan;
   assign conv_sample_o       = s_reg.sample;
   assign rc_enable_o         = s_reg.cfg1[CFG1_RC];
   assign bc_enable_o         = s_reg.cfg1[CFG1_BC];
   assign alert_oe_n_o        = s_reg.alert_oe_n;
   assign overtemp_out_oe_n_o = s_reg.ot_oe_n;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (reset_i);

   a_ot_mask_out:     assert property (overtemp_out_oe_n_o == !(|(s_reg.ot_act & ~s_reg.mask_ot)))
      else $error("overtemp output disagrees with masked state");
   a_local_alert_set: assert property (ce_i && sample_ev && s_reg.chan == LOCAL_CH && !s_reg.alert_act[6]
                                       && meas_temp_i > s_reg.alert_lim[0] && !soft_rst |=> s_reg.status1[6])
      else $error("local alert flag not set");
   a_remote_alert_set: assert property (ce_i && sample_ev && s_reg.chan != LOCAL_CH
                                        && meas_temp_i > s_reg.alert_lim[s_reg.chan] && !soft_rst
                                        |=> s_reg.status1[$past(s_reg.chan) - 3'h1])
      else $error("remote alert flag not set");
   a_rc_extra_time:   assert property (ce_i && load_ev && nxt_chan == 3'h1 && s_reg.cfg1[CFG1_RC]
                                       && !soft_rst |=> s_reg.timer == RC_LOAD)
      else $error("channel 1 conversion not lengthened");
   a_skip_faulted:    assert property (load_ev |-> nxt_chan == LOCAL_CH || !s_reg.fault[nxt_chan])
      else $error("faulted channel selected");
   a_diode_fault_flag: assert property (ce_i && !(reg_wr_i && reg_addr_i == ADDR_CFG1)
                                        |=> s_reg.fault[6:1] == $past(fault_raw))
      else $error("diode fault not reported");
   a_alert_mask_out:  assert property (alert_oe_n_o == !(|(s_reg.status1 & ~s_reg.mask_alert)))
      else $error("alert output disagrees with masked status");
   a_st2_read_clear:  assert property (ce_i && reg_rd_i && reg_addr_i == ADDR_ST2 && !sample_ev && !reg_wr_i
                                       |=> s_reg.status2 == 8'h00 && $stable(overtemp_out_oe_n_o))
      else $error("status2 read misbehaved");
   a_hyst_hold:       assert property (ce_i && sample_ev && OT_CH_MASK[s_reg.chan]
                                       && s_reg.ot_act[s_reg.chan - 3'h1] && !soft_rst
                                       && ({1'b0, meas_temp_i} + 9'(HYST_DEGC)) > {1'b0, s_reg.ot_lim[s_reg.chan]}
                                       |=> s_reg.ot_act[$past(s_reg.chan) - 3'h1])
      else $error("fault released inside hysteresis");
   a_reserved_zero:   assert property ((s_reg.mask_ot & ~OT_BITS) == 8'h00 && !s_reg.status1[7]
                                       && (s_reg.status2 & ~OT_BITS) == 8'h00)
      else $error("reserved bit set");
   a_cancel_follows:  assert property (ce_i && reg_wr_i && reg_addr_i == ADDR_CFG1 && !soft_rst
                                       |=> {rc_enable_o, bc_enable_o} == $past(reg_wdata_i[CFG1_RC:CFG1_BC]))
      else $error("front end enables wrong");
endmodule
`default_nettype wire

// >>> hw/temp_alarm_pkg.sv
// Constants for the temperature channel alarm and status logic.
// Assumes an 8-bit command-byte register port and 8-bit unsigned temperatures.
package temp_alarm_pkg;

   // -----------------------------------------------------------------
   // Channels and timing
   // -----------------------------------------------------------------
   localparam int          NUM_CH      = 7;
   localparam int          CH_W        = 3;
   localparam logic [2:0]  LOCAL_CH    = 3'h0;
   localparam logic [2:0]  LAST_CH     = 3'h6;
   localparam int          CLK_KHZ     = 50_000;
   localparam int          RC_EXTRA_MS = 125;
   localparam int          HYST_DEGC   = 4;

   // -----------------------------------------------------------------
   // Register command codes
   // -----------------------------------------------------------------
   localparam logic [7:0] ADDR_CFG1       = 8'h41;
   localparam logic [7:0] ADDR_CFG2       = 8'h42;
   localparam logic [7:0] ADDR_CFG3       = 8'h43;
   localparam logic [7:0] ADDR_ST1        = 8'h44;
   localparam logic [7:0] ADDR_ST2        = 8'h45;
   localparam logic [7:0] ADDR_ST3        = 8'h46;
   localparam logic [7:0] ADDR_MFR_ID     = 8'h0A;
   localparam logic [4:0] ADDR_TEMP_HI    = 5'h00;
   localparam logic [3:0] ADDR_ALIM_HI    = 4'h1;
   localparam logic [3:0] ADDR_OLIM_HI    = 4'h2;
   localparam logic [2:0] ALIM_LOCAL_IDX  = 3'h7;

   // -----------------------------------------------------------------
   // Field layout and reset values
   // -----------------------------------------------------------------
   localparam int         CFG1_STOP  = 7;
   localparam int         CFG1_POR   = 6;
   localparam int         CFG1_RC    = 3;
   localparam int         CFG1_BC    = 2;
   localparam logic [7:0] CFG1_RST   = 8'h0C;
   localparam logic [7:0] CFG1_WMASK = 8'hAC;
   localparam logic [7:0] ST1_BITS   = 8'h7F;
   localparam logic [7:0] ST1_LOCAL  = 8'h40;
   localparam logic [7:0] OT_BITS    = 8'h39;
   localparam logic [7:0] OT_CH_MASK = 8'h72;
   localparam logic [7:0] ONE_HOT0   = 8'h01;

   localparam logic [6:0][7:0] ALERT_LIM_RST =
      {8'h64, 8'h64, 8'h64, 8'h64, 8'h7F, 8'h6E, 8'h5A};
   localparam logic [6:0][7:0] OT_LIM_RST =
      {8'h5A, 8'h5A, 8'h7F, 8'h00, 8'h00, 8'h6E, 8'h00};

   typedef enum logic {SEQ_STANDBY, SEQ_CONVERT} seq_e;

endpackage

// >>> hw/temp_limit_cmp.sv
// One channel limit comparator with release hysteresis.
// Assumes unsigned 8-bit temperature and limit codes.
`timescale 1ns/1ps
`default_nettype none
module temp_limit_cmp
   import temp_alarm_pkg::*;
#(
   parameter int HYST = HYST_DEGC
)
(
   input  wire logic [7:0] temp_i,
   input  wire logic [7:0] limit_i,
   input  wire logic       active_i,
   output logic            active_o
);

   logic [8:0] temp_plus_hyst;

   assign temp_plus_hyst = {1'b0, temp_i} + 9'(HYST);

   // Trip above limit; release only once temp + hyst <= limit
   assign active_o = active_i ? (temp_plus_hyst > {1'b0, limit_i})
                              : (temp_i > limit_i);
endmodule
`default_nettype wire

// >>> verification/smbus_host_model.sv
// Host model: command-byte register master for the alarm block.
// Assumes requests are taken on a rising edge, one per cycle.
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model
   import temp_alarm_pkg::*;
(
   input  wire logic       mclk_i,
   output logic      [7:0] addr_o,
   output logic            wr_o,
   output logic            rd_o,
   output logic      [7:0] wdata_o
);
   initial
   begin
      addr_o  = 8'hFF;
      wr_o    = 1'b0;
      rd_o    = 1'b0;
      wdata_o = 8'hFF;
   end

   // -----------------------------------------------------------------
   // Bus cycles
   // -----------------------------------------------------------------
   // Held over one taken edge; released address and data show the inverse, strobes drop low
   task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      #1;
      addr_o  = a;
      wdata_o = d;
      wr_o    = w;
      rd_o    = !w;
      @(posedge mclk_i);
      #1;
      wr_o    = 1'b0;
      rd_o    = 1'b0;
      addr_o  = ~a;
      wdata_o = ~d;
   endtask

   // Beta compensation never without resistance cancellation
   task automatic set_cfg1(input logic [7:0] d);
      access(1'b1, ADDR_CFG1, d[2] ? (d | 8'h08) : d);
   endtask

   // Masks for unused channels
   task automatic mask_unused(input logic [7:0] am, input logic [7:0] om);
      access(1'b1, ADDR_CFG2, am);
      access(1'b1, ADDR_CFG3, om);
   endtask
endmodule
`default_nettype wire

// >>> verification/test_temp_channel_alarm_status.sv
// Testbench for the channel alarm and status block.
// Assumes the host model drives the register port, the bench the front end.
`timescale 1ns/1ps
`default_nettype none
module test_temp_channel_alarm_status
   import temp_alarm_pkg::*;
;
   logic       mclk_i   = 1'b0;
   logic       reset_i  = 1'b1;
   logic       ce_i     = 1'b1;
   logic       rd_taken = 1'b0;
   logic [5:0] an_open  = 6'h00;
   logic [5:0] ca_open  = 6'h00;
   logic [5:0] an_sup   = 6'h00;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, temp_v;
   logic       reg_wr, reg_rd, conv_sample, rc_en, bc_en, alert_n, ot_n;
   logic [2:0] conv_chan;
   logic [2:0] prev_ch  = 3'h0;
   logic [2:0] hold_ch  = 3'h0;
   logic [7:0] tv [0:6];
   logic [7:0] exp_q [$];
   int         n_mismatch = 0;
   int         samples_checked = 0;
   int         run = 0;
   int         len [0:7];
   int         seen [0:7];

   always #10 mclk_i = ~mclk_i;
   assign temp_v = tv[conv_chan];

   smbus_host_model i_smbus_host_model (.mclk_i(mclk_i), .addr_o(reg_addr), .wr_o(reg_wr),
      .rd_o(reg_rd), .wdata_o(reg_wdata));

   temp_channel_alarm_status #(.BASE_CONV_CYC(8), .RC_EXTRA_CYC(20),
      .MFR_ID(8'h3B)) // Arbitrary value
   i_temp_channel_alarm_status (.mclk_i(mclk_i), .reset_i(reset_i), .ce_i(ce_i),
      .reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata),
      .reg_rdata_o(reg_rdata), .meas_temp_i(temp_v), .diode_anode_open_i(an_open),
      .diode_cathode_open_i(ca_open), .diode_anode_at_supply_i(an_sup),
      .conv_chan_o(conv_chan), .conv_sample_o(conv_sample), .rc_enable_o(rc_en),
      .bc_enable_o(bc_en), .alert_oe_n_o(alert_n), .overtemp_out_oe_n_o(ot_n));

   // -----------------------------------------------------------------
   // Checking
   // -----------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         n_mismatch++;
      end
   endtask

   task automatic close_out;
      if (exp_q.size() != 0)
         n_mismatch++;
      $display("Checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      i_smbus_host_model.access(1'b0, a, 8'h00);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_smbus_host_model.access(1'b1, a, d);
   endtask

   // Waits for n sample pulses, bounded
   task automatic seq(input int n);
      int t;
      repeat (n)
      begin
         t = 0;
         do
         begin
            @(negedge mclk_i);
            t++;
         end
         while (conv_sample !== 1'b1 && t < 200);
         if (t >= 200)
            chk(16'h0, 16'h1);
      end
      @(posedge mclk_i);
      #1;
   endtask

   always @(posedge mclk_i)
      rd_taken <= reg_rd & ce_i;

   // Read data and window lengths per channel
   always @(negedge mclk_i)
   begin
      if (rd_taken && exp_q.size() > 0)
         chk(reg_rdata, exp_q.pop_front());
      if (conv_chan == prev_ch)
         run++;
      else
      begin
         len[prev_ch] = run;
         seen[prev_ch]++;
         run = 1;
      end
      prev_ch = conv_chan;
   end

   initial
   begin
      #400000;
      n_mismatch++;
      close_out();
   end

   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   initial
   begin
      foreach (tv[i])
         tv[i] = 8'h30;
      void'($urandom(32'h090A));
      repeat (3) @(posedge mclk_i);
      #1;
      reset_i = 1'b0;
      chk({rc_en, bc_en}, 2'b11);
      rd(ADDR_CFG1, 8'h0C);
      rd(ADDR_CFG3, 8'h00);
      rd(ADDR_MFR_ID, 8'h3B);
      rd(8'h7E, 8'h00);
      wr(ADDR_ST1, 8'hFF);
      rd(ADDR_ST1, 8'h00);
      seq(16);
      chk(16'(len[1] - len[2]), 16'd20);
      i_smbus_host_model.set_cfg1(8'h00);
      seq(16);
      chk({rc_en, bc_en}, 2'b00);
      chk(16'(len[1] - len[2]), 16'd0);
      i_smbus_host_model.set_cfg1(8'h37);
      rd(ADDR_CFG1, 8'h2C);
      chk({rc_en, bc_en}, 2'b11);
      tv[0] = 8'h60;
      tv[3] = 8'h70;
      tv[2] = 8'($urandom_range(0, 127));
      seq(8);
      chk(alert_n, 1'b0);
      wr(ADDR_CFG2, 8'hC4);
      rd(ADDR_CFG2, 8'h44);
      tv[0] = 8'h20;
      tv[3] = 8'h20;
      seq(8);
      chk(alert_n, 1'b1);
      rd(ADDR_ST1, 8'h44);
      rd(ADDR_ST1, 8'h00);
      wr(ADDR_CFG2, 8'h00);
      seq(1);
      chk(alert_n, 1'b1);
      tv[5] = 8'h60;
      seq(8);
      chk(ot_n, 1'b0);
      rd(ADDR_ST2, 8'h10);
      chk(ot_n, 1'b0);
      wr(ADDR_CFG3, 8'hEF);
      rd(ADDR_CFG3, 8'h29);
      seq(1);
      chk(ot_n, 1'b0);
      wr(ADDR_CFG3, 8'h10);
      seq(1);
      chk(ot_n, 1'b1);
      wr(ADDR_CFG3, 8'h00);
      tv[5] = 8'h57;
      seq(8);
      chk(ot_n, 1'b0);
      tv[5] = 8'h56;
      seq(8);
      chk(ot_n, 1'b1);
      rd(8'h05, 8'h56);
      an_open = 6'h24;
      ca_open = 6'h04;
      an_sup  = 6'h10;
      i_smbus_host_model.mask_unused(8'h14, 8'h10);
      seq(8);
      rd(ADDR_ST3, 8'h28);
      foreach (seen[i])
         seen[i] = 0;
      seq(8);
      chk(16'(seen[3] + seen[5]), 16'd0);
      chk(seen[6] > 0, 1'b1);
      // Clock enable low freezes the sequencer
      hold_ch = conv_chan;
      ce_i = 1'b0;
      repeat (20) @(posedge mclk_i);
      #1;
      chk(conv_chan, hold_ch);
      ce_i = 1'b1;
      // Stop bit parks the sequencer after its window
      wr(ADDR_CFG1, 8'h80);
      repeat (40) @(posedge mclk_i);
      #1;
      hold_ch = conv_chan;
      repeat (40) @(posedge mclk_i);
      #1;
      chk(conv_chan, hold_ch);
      // Limit write, then soft reset restores defaults
      wr(8'h15, 8'h58);
      rd(8'h15, 8'h58);
      wr(ADDR_CFG1, 8'h40);
      rd(8'h15, 8'h64);
      rd(ADDR_CFG3, 8'h00);
      chk({rc_en, bc_en}, 2'b11);
      repeat (2) @(negedge mclk_i);
      close_out();
   end
endmodule
`default_nettype wire
